// ===== verilog/lock_fwd_pkg.sv
// Purpose: shared constants and types for the locked transaction forwarder
// Assumes: pci command codes as on the c/be lines during the address phase
// Notes: all signals active high inside the block except the active low reset rst_b_in
package lock_fwd_pkg;
	localparam logic [3:0] cmd_io_read = 4'h2;
	localparam logic [3:0] cmd_io_write = 4'h3;
	localparam logic [3:0] cmd_mem_read = 4'h6;
	localparam logic [3:0] cmd_mem_write = 4'h7;
	localparam logic [3:0] cmd_cfg_read = 4'ha;
	localparam logic [3:0] cmd_cfg_write = 4'hb;
	localparam int req_backoff_cycles = 2;
	localparam logic [1:0] backoff_reset = 2'h0;

	typedef enum {
		lk_idle,
		lk_queued,
		lk_wait_bus,
		lk_issue,
		lk_tgt_locked,
		lk_both_locked,
		lk_aborted,
		lk_release
	} lock_state_type;

	typedef enum logic [1:0] {
		resp_none,
		resp_retry,
		resp_master_abort,
		resp_target_abort
	} resp_type;
endpackage

// ===== verilog/preq_if.sv
// Purpose: carries primary arbitration signals between the lock block and arbiter
// Assumes: one clock domain
// Notes: active high levels
`timescale 1ns/1ps
interface preq_if;
	logic upstream_pending;
	logic fully_queued;
	logic retry_seen;
	logic grant;
	logic bus_idle;
	logic req;
	logic start;
	logic park;
	modport arb (input upstream_pending, input fully_queued, input retry_seen,
		input grant, input bus_idle, output req, output start, output park);
	modport user (output upstream_pending, output fully_queued, output retry_seen,
		output grant, output bus_idle, input req, input start, input park);
endinterface

// ===== verilog/primary_arbiter_req.sv
// Purpose: primary bus request, start and parking
// Assumes: external primary arbiter
// Notes: request backs off after a retry
`timescale 1ns/1ps
module primary_arbiter_req (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	preq_if.arb p
);
	import lock_fwd_pkg::*;

	typedef struct packed {
		logic [1:0] backoff;
		logic req;
		logic gnt_prev;
		logic start;
		logic park;
	} arb_state_type;

	arb_state_type s_r;
	arb_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.gnt_prev = p.grant;
		s_nxt.start = 1'b0;
		if (p.retry_seen) begin
			s_nxt.backoff = 2'(req_backoff_cycles);
		end else if (s_r.backoff != 2'h0) begin
			s_nxt.backoff = s_r.backoff - 2'h1;
		end
		s_nxt.req = p.upstream_pending && p.fully_queued && !p.retry_seen &&
			(s_r.backoff <= 2'h1);
		// start after grant, park without request
		if (s_r.req && p.grant && p.bus_idle) begin
			s_nxt.start = s_r.park ? s_r.gnt_prev : 1'b1;
		end
		s_nxt.park = p.grant && !s_r.req && p.bus_idle;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			s_r <= '{backoff: backoff_reset, default: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign p.req = s_r.req;
	assign p.start = s_r.start;
	assign p.park = s_r.park;

	property p_backoff_drop;
		@(posedge mclk_in) disable iff (!rst_b_in)
		p.retry_seen |=> !p.req [*2];
	endproperty
	a_backoff_drop: assert property (p_backoff_drop) else $error("request not dropped");

	property p_req_needs_work;
		@(posedge mclk_in) disable iff (!rst_b_in)
		p.req |-> $past(p.upstream_pending && p.fully_queued);
	endproperty
	a_req_needs_work: assert property (p_req_needs_work) else $error("request without work");

	property p_park_no_req;
		@(posedge mclk_in) disable iff (!rst_b_in)
		p.park |-> $past(p.grant && !p.req);
	endproperty
	a_park_no_req: assert property (p_park_no_req) else $error("bad park");

	c_start: cover property (@(posedge mclk_in) disable iff (!rst_b_in) p.start);
endmodule

// ===== verilog/locked_transaction_forwarder.sv
// Purpose: lock tracking across the bridge plus primary request logic
// Assumes: pci signals already decoded to active high events by the bus units
// Notes: every output is registered
`timescale 1ns/1ps
module locked_transaction_forwarder (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// primary side request decode
	input wire logic pri_req_valid_in,
	input wire logic pri_req_locked_in,
	input wire logic pri_req_downstream_in,
	input wire logic [3:0] primary_command_byte_enables_in,
	input wire logic [31:0] pri_addr_in,
	input wire logic [3:0] pri_be_in,
	input wire logic primary_parity_line_in,
	input wire logic pri_lock_in,
	input wire logic pri_frame_in,
	input wire logic pri_write_done_in,
	// secondary side
	input wire logic sec_req_valid_in,
	input wire logic sec_lock_busy_in,
	input wire logic sec_bus_idle_in,
	input wire logic sec_data_done_in,
	input wire logic sec_target_abort_in,
	input wire logic sec_master_abort_in,
	input wire logic sec_retry_in,
	input wire logic queue_empty_in,
	input wire logic master_timeout_in,
	input wire logic serr_enable_in,
	input wire logic master_abort_mode_in,
	// primary arbitration
	input wire logic upstream_pending_in,
	input wire logic upstream_queued_in,
	input wire logic pri_init_retry_in,
	input wire logic pri_gnt_in,
	input wire logic pri_bus_idle_in,
	output logic pri_req_out,
	output logic pri_start_out,
	output logic pri_park_out,
	// results
	output lock_fwd_pkg::resp_type pri_resp_out,
	output logic enqueue_out,
	output logic enqueue_locked_out,
	output logic prefetch_ok_out,
	output logic sec_req_out,
	output logic sec_lock_out,
	output logic sec_issue_locked_out,
	output logic discard_read_out,
	output logic serr_out,
	output logic status_tabort_out,
	output logic status_mabort_out,
	output logic pri_locked_out,
	output logic [39:0] captured_out
);
	import lock_fwd_pkg::*;

	typedef struct packed {
		lock_state_type st;
		resp_type resp;
		resp_type abort_kind;
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be;
		logic par;
		logic first;
		logic enq;
		logic enq_lk;
		logic prefetch;
		logic sreq;
		logic slock;
		logic issue;
		logic discard;
		logic serr;
		logic tabort;
		logic mabort;
		logic plock;
	} lock_reg_type;

	lock_reg_type s_r;
	lock_reg_type s_nxt;
	logic new_lock;
	logic match;
	logic down_req;

	preq_if pq();

	assign pq.upstream_pending = upstream_pending_in;
	assign pq.fully_queued = upstream_queued_in;
	assign pq.retry_seen = pri_init_retry_in;
	assign pq.grant = pri_gnt_in;
	assign pq.bus_idle = pri_bus_idle_in;

	primary_arbiter_req primary_arbiter_req_inst (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.p(pq.arb)
	);

	assign down_req = pri_req_valid_in && pri_req_downstream_in;
	assign new_lock = down_req && pri_req_locked_in;
	assign match = pri_addr_in == s_r.addr && primary_command_byte_enables_in == s_r.cmd &&
		pri_be_in == s_r.be;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.resp = resp_none;
		s_nxt.enq = 1'b0;
		s_nxt.enq_lk = 1'b0;
		s_nxt.discard = 1'b0;
		s_nxt.serr = 1'b0;
		s_nxt.prefetch = !pri_req_locked_in;
		if (sec_req_valid_in && s_r.st == lk_idle) begin
			s_nxt.enq = 1'b1;
		end
		if (down_req && s_r.st inside {lk_queued, lk_wait_bus, lk_issue, lk_release}) begin
			s_nxt.resp = resp_retry;
		end
		unique case (s_r.st)
			lk_idle: begin
				if (new_lock) begin
					if (sec_lock_busy_in) begin
						s_nxt.resp = resp_retry;
					end else if (primary_command_byte_enables_in != cmd_mem_read) begin
						s_nxt.resp = resp_master_abort;
					end else begin
						s_nxt.addr = pri_addr_in;
						s_nxt.cmd = primary_command_byte_enables_in;
						s_nxt.be = pri_be_in;
						s_nxt.par = primary_parity_line_in;
						s_nxt.enq = 1'b1;
						s_nxt.enq_lk = 1'b1;
						s_nxt.prefetch = 1'b0;
						s_nxt.resp = resp_retry;
						s_nxt.first = 1'b1;
						s_nxt.st = lk_queued;
					end
				end else if (down_req) begin
					s_nxt.enq = 1'b1;
				end
			end
			lk_queued: begin
				if (queue_empty_in) begin
					s_nxt.st = lk_wait_bus;
				end
			end
			lk_wait_bus: begin
				if (!sec_lock_busy_in && sec_bus_idle_in) begin
					s_nxt.sreq = 1'b1;
					s_nxt.issue = 1'b1;
					s_nxt.st = lk_issue;
				end
			end
			lk_issue: begin
				s_nxt.slock = 1'b1;
				if (sec_data_done_in) begin
					s_nxt.sreq = 1'b0;
					s_nxt.st = lk_tgt_locked;
				end else if (sec_target_abort_in || sec_master_abort_in) begin
					s_nxt.sreq = 1'b0;
					s_nxt.slock = 1'b0;
					s_nxt.issue = 1'b0;
					s_nxt.abort_kind = sec_target_abort_in ? resp_target_abort :
						resp_master_abort;
					s_nxt.st = lk_aborted;
				end else if (sec_retry_in && s_r.first) begin
					s_nxt.slock = 1'b0;
					s_nxt.st = lk_wait_bus;
				end
			end
			lk_tgt_locked: begin
				if (master_timeout_in) begin
					s_nxt.discard = 1'b1;
					s_nxt.serr = serr_enable_in;
					s_nxt.st = lk_release;
				end else if (new_lock && match) begin
					s_nxt.plock = 1'b1;
					s_nxt.first = 1'b0;
					s_nxt.st = lk_both_locked;
				end else if (down_req) begin
					s_nxt.resp = resp_retry;
				end
			end
			lk_both_locked: begin
				if (new_lock) begin
					s_nxt.enq = 1'b1;
					s_nxt.enq_lk = 1'b1;
				end else if (down_req) begin
					s_nxt.resp = resp_retry;
				end
				if (sec_target_abort_in || (sec_master_abort_in && master_abort_mode_in)) begin
					s_nxt.serr = serr_enable_in;
				end
				if (pri_write_done_in && !pri_lock_in) begin
					s_nxt.st = lk_release;
				end else if (!pri_lock_in && !pri_frame_in) begin
					s_nxt.st = lk_release;
				end
			end
			lk_aborted: begin
				if (new_lock && match) begin
					s_nxt.resp = s_r.abort_kind;
					s_nxt.tabort = s_r.tabort || s_r.abort_kind == resp_target_abort;
					s_nxt.mabort = s_r.mabort || s_r.abort_kind == resp_master_abort;
					s_nxt.st = lk_idle;
				end
			end
			lk_release: begin
				s_nxt.slock = 1'b0;
				s_nxt.issue = 1'b0;
				s_nxt.plock = 1'b0;
				s_nxt.st = lk_idle;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			s_r <= '{st: lk_idle, resp: resp_none, abort_kind: resp_none, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			pri_req_out <= 1'b0;
			pri_start_out <= 1'b0;
			pri_park_out <= 1'b0;
		end else begin
			pri_req_out <= pq.req;
			pri_start_out <= pq.start;
			pri_park_out <= pq.park;
		end
	end

	assign pri_resp_out = s_r.resp;
	assign enqueue_out = s_r.enq;
	assign enqueue_locked_out = s_r.enq_lk;
	assign prefetch_ok_out = s_r.prefetch;
	assign sec_req_out = s_r.sreq;
	assign sec_lock_out = s_r.slock;
	assign sec_issue_locked_out = s_r.issue;
	assign discard_read_out = s_r.discard;
	assign serr_out = s_r.serr;
	assign status_tabort_out = s_r.tabort;
	assign status_mabort_out = s_r.mabort;
	assign pri_locked_out = s_r.plock;
	assign captured_out = {s_r.addr[31:0], s_r.cmd, s_r.be[3:1], s_r.par};

	////////////////////////////////////////////////////////////////////////
	property p_conflict_retry;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(s_r.st == lk_idle && new_lock && sec_lock_busy_in) |=> pri_resp_out == resp_retry;
	endproperty
	a_conflict_retry: assert property (p_conflict_retry) else $error("no retry");

	property p_bad_first;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(s_r.st == lk_idle && new_lock && !sec_lock_busy_in &&
			primary_command_byte_enables_in == cmd_io_write) |=>
			pri_resp_out == resp_master_abort;
	endproperty
	a_bad_first: assert property (p_bad_first) else $error("no master abort");

	property p_no_prefetch;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(pri_req_locked_in && pri_req_valid_in) |=> !prefetch_ok_out;
	endproperty
	a_no_prefetch: assert property (p_no_prefetch) else $error("locked prefetch");

	property p_hold_others;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(down_req && (s_r.st inside {lk_queued, lk_wait_bus, lk_issue} ||
			(s_r.st == lk_tgt_locked && !new_lock && !master_timeout_in))) |=>
			pri_resp_out == resp_retry && !enqueue_out;
	endproperty
	a_hold_others: assert property (p_hold_others) else $error("crossing not retried");

	property p_wait_drain;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(s_r.st == lk_queued && !queue_empty_in) |=> !sec_req_out;
	endproperty
	a_wait_drain: assert property (p_wait_drain) else $error("issued early");

	property p_timeout_release;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(s_r.st == lk_tgt_locked && master_timeout_in) |=> discard_read_out ##1 !sec_lock_out;
	endproperty
	a_timeout_release: assert property (p_timeout_release) else $error("timeout kept lock");

	property p_abort_nolock;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(s_r.st == lk_issue && !sec_data_done_in &&
			(sec_target_abort_in || sec_master_abort_in)) |=>
			!sec_lock_out && !pri_locked_out;
	endproperty
	a_abort_nolock: assert property (p_abort_nolock) else $error("lock after abort");

	property p_release;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(s_r.st == lk_both_locked && !pri_lock_in && !pri_frame_in) |=> ##1 !sec_lock_out;
	endproperty
	a_release: assert property (p_release) else $error("lock not released");

	c_lock_both: cover property (@(posedge mclk_in) disable iff (!rst_b_in) pri_locked_out);
	c_abort: cover property (@(posedge mclk_in) disable iff (!rst_b_in) s_r.st == lk_aborted);
	c_timeout: cover property (@(posedge mclk_in) disable iff (!rst_b_in) discard_read_out);
endmodule

// ===== verif/sec_target_model.sv
// Purpose: secondary target answering the bridge's locked read
// Assumes: one clock, answer after a programmable delay
// Notes: bus idle only while no request is being served
`timescale 1ns/1ps
module sec_target_model (
	input wire logic mclk_in,
	input wire logic sec_req_in,
	input wire logic [1:0] mode_in,
	input wire logic [3:0] delay_in,
	output logic data_done_out,
	output logic tabort_out,
	output logic mabort_out,
	output logic bus_idle_out
);
	logic [3:0] cnt_r = 4'h0;
	logic done_r = 1'b0;
	initial begin
		data_done_out = 1'b0;
		tabort_out = 1'b0;
		mabort_out = 1'b0;
		bus_idle_out = 1'b1;
	end
	always @(posedge mclk_in) begin
		data_done_out <= 1'b0;
		tabort_out <= 1'b0;
		mabort_out <= 1'b0;
		bus_idle_out <= !sec_req_in;
		if (!sec_req_in) begin
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end else if (!done_r && cnt_r == delay_in) begin
			done_r <= 1'b1;
			data_done_out <= (mode_in == 2'h0);
			tabort_out <= (mode_in == 2'h1);
			mabort_out <= (mode_in == 2'h2);
		end else if (!done_r) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// ===== verif/locked_transaction_forwarder_bench.sv
// Purpose: self-checking bench for the lock forwarder
// Assumes: secondary target model on the far side
// Notes: waits are bounded polls
`timescale 1ns/1ps
module locked_transaction_forwarder_bench;
	import lock_fwd_pkg::*;
	logic mclk_in = 1'b0, rst_b_in = 1'b0;
	logic rv = 1'b0, rl = 1'b0, rd = 1'b0, par = 1'b1, plk = 1'b0, pfr = 1'b0;
	logic [3:0] cmd = 4'h0, be = 4'ha;
	logic [31:0] addr = 32'h0000_1000;
	logic srv = 1'b0, qe = 1'b0, upend = 1'b0, uq = 1'b0, iretry = 1'b0, gnt = 1'b0;
	logic pwd = 1'b0, busy = 1'b0, wta = 1'b0, mto = 1'b0;
	logic sdone, sta, sma, sidle;
	logic [1:0] mode = 2'h0;
	logic preq, pstart, ppark, enq, enql, pfo, sreq, slock, siss, disc, serr, sta_o, sma_o;
	logic plocked;
	resp_type resp;
	logic [39:0] capt;
	int err_total = 0, checks = 0;
	initial begin
		forever #2.5 mclk_in = !mclk_in;
	end
	locked_transaction_forwarder locked_transaction_forwarder_inst (.mclk_in(mclk_in),
		.rst_b_in(rst_b_in), .pri_req_valid_in(rv), .pri_req_locked_in(rl),
		.pri_req_downstream_in(rd), .primary_command_byte_enables_in(cmd),
		.pri_addr_in(addr), .pri_be_in(be), .primary_parity_line_in(par), .pri_lock_in(plk),
		.pri_frame_in(pfr), .pri_write_done_in(pwd), .sec_req_valid_in(srv),
		.sec_lock_busy_in(busy), .sec_bus_idle_in(sidle), .sec_data_done_in(sdone),
		.sec_target_abort_in(sta | wta), .sec_master_abort_in(sma), .sec_retry_in(1'b0),
		.queue_empty_in(qe), .master_timeout_in(mto), .serr_enable_in(1'b1),
		.master_abort_mode_in(1'b0), .upstream_pending_in(upend), .upstream_queued_in(uq),
		.pri_init_retry_in(iretry), .pri_gnt_in(gnt), .pri_bus_idle_in(1'b1),
		.pri_req_out(preq), .pri_start_out(pstart), .pri_park_out(ppark),
		.pri_resp_out(resp), .enqueue_out(enq), .enqueue_locked_out(enql),
		.prefetch_ok_out(pfo), .sec_req_out(sreq), .sec_lock_out(slock),
		.sec_issue_locked_out(siss), .discard_read_out(disc), .serr_out(serr),
		.status_tabort_out(sta_o), .status_mabort_out(sma_o), .pri_locked_out(plocked),
		.captured_out(capt));
	sec_target_model sec_target_model_inst (.mclk_in(mclk_in), .sec_req_in(sreq),
		.mode_in(mode), .delay_in(4'h3), .data_done_out(sdone), .tabort_out(sta),
		.mabort_out(sma), .bus_idle_out(sidle));
	////////////////////////////////////////////////////////////////////////////
	task step;
		@(posedge mclk_in);
		#1;
	endtask
	task chk(input string name, input logic [39:0] exp, input logic [39:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic logic sig(input int sel);
		case (sel)
			0: return resp === resp_retry;
			1: return resp === resp_master_abort;
			2: return resp === resp_target_abort;
			3: return enql === 1'b1;
			4: return siss === 1'b1;
			5: return slock === 1'b1;
			6: return slock === 1'b0;
			7: return plocked === 1'b1;
			8: return sta_o === 1'b1;
			9: return preq === 1'b1;
			10: return preq === 1'b0;
			11: return pstart === 1'b1;
			default: return ppark === 1'b1;
		endcase
	endfunction
	task wait_for(input int sel, input string name);
		int n;
		n = 0;
		while (!sig(sel) && n < 12) begin
			step;
			n++;
		end
		chk(name, 40'h1, {39'h0, sig(sel)});
	endtask
	task preq_send(input logic [3:0] c, input logic lk);
		step;
		rv = 1'b1;
		rl = lk;
		rd = 1'b1;
		cmd = c;
		step;
		rv = 1'b0;
		rl = 1'b0;
		if (lk) begin
			plk = 1'b1;
		end
	endtask
	// bus idle, lock free before next
	task end_lock;
		plk = 1'b0;
		pfr = 1'b0;
		qe = 1'b0;
		repeat (4) step;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_lock_seq;
		preq_send(cmd_mem_read, 1'b1);
		wait_for(3, "enqueue_locked");
		chk("captured", {addr, cmd_mem_read, be[3:1], par}, capt);
		preq_send(cmd_mem_write, 1'b0);
		wait_for(0, "crossing retry");
		chk("enqueue", 40'h0, {39'h0, enq});
		repeat (3) step;
		chk("sec_req early", 40'h0, {39'h0, sreq});
		qe = 1'b1;
		wait_for(4, "issue locked");
		wait_for(5, "sec lock");
		repeat (6) step;
		preq_send(cmd_mem_read, 1'b1);
		wait_for(7, "pri locked");
		chk("prefetch", 40'h0, {39'h0, pfo});
		end_lock;
		wait_for(6, "sec lock free");
		$display("t_lock_seq done");
	endtask
	task t_bad_first;
		logic [3:0] bad [5];
		bad = '{cmd_io_read, cmd_io_write, cmd_mem_write, cmd_cfg_read, cmd_cfg_write};
		foreach (bad[i]) begin
			preq_send(bad[i], 1'b1);
			wait_for(1, "bad first master abort");
			end_lock;
		end
		$display("t_bad_first done");
	endtask
	task t_abort;
		mode = 2'h1;
		preq_send(cmd_mem_read, 1'b1);
		qe = 1'b1;
		wait_for(5, "abort sec lock");
		wait_for(6, "no sec lock");
		chk("status early", 40'h0, {39'h0, sta_o});
		preq_send(cmd_mem_read, 1'b1);
		wait_for(2, "repeat target abort");
		wait_for(8, "target abort status");
		chk("pri locked", 40'h0, {39'h0, plocked});
		end_lock;
		mode = 2'h0;
		$display("t_abort done");
	endtask
	task t_primary;
		srv = 1'b1;
		step;
		srv = 1'b0;
		repeat (3) step;
		chk("upstream lock", 40'h0, {38'h0, slock, plocked});
		upend = 1'b1;
		uq = 1'b1;
		wait_for(9, "pri req");
		iretry = 1'b1;
		step;
		iretry = 1'b0;
		repeat (2) begin
			step;
			chk("req backoff", 40'h0, {39'h0, preq});
		end
		step;
		chk("req again", 40'h1, {39'h0, preq});
		gnt = 1'b1;
		wait_for(11, "start");
		upend = 1'b0;
		uq = 1'b0;
		wait_for(10, "req drop");
		wait_for(12, "park");
		gnt = 1'b0;
		$display("t_primary done");
	endtask
	task t_conflict;
		busy = 1'b1;
		preq_send(cmd_mem_read, 1'b1);
		wait_for(0, "conflict retry");
		chk("conflict enqueue", 40'h0, {39'h0, enql});
		busy = 1'b0;
		end_lock;
		preq_send(cmd_mem_read, 1'b1);
		busy = 1'b1;
		qe = 1'b1;
		repeat (4) step;
		chk("sec_req while busy", 40'h0, {39'h0, sreq});
		busy = 1'b0;
		wait_for(4, "issue after free");
		repeat (6) step;
		mto = 1'b1;
		step;
		mto = 1'b0;
		chk("discard", 40'h1, {39'h0, disc});
		chk("timeout serr", 40'h1, {39'h0, serr});
		wait_for(6, "timeout unlock");
		end_lock;
		$display("t_conflict done");
	endtask
	task t_posted;
		preq_send(cmd_mem_read, 1'b1);
		qe = 1'b1;
		wait_for(5, "posted sec lock");
		repeat (6) step;
		preq_send(cmd_mem_read, 1'b1);
		wait_for(7, "posted pri locked");
		preq_send(cmd_mem_write, 1'b1);
		wait_for(3, "locked write forwarded");
		wta = 1'b1;
		step;
		wta = 1'b0;
		chk("posted abort serr", 40'h1, {39'h0, serr});
		pwd = 1'b1;
		pfr = 1'b1;
		plk = 1'b0;
		step;
		pwd = 1'b0;
		wait_for(6, "write end unlock");
		end_lock;
		$display("t_posted done");
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		complete_run;
	end
	initial begin
		repeat (4) step;
		rst_b_in = 1'b1;
		step;
		chk("reset outs", 40'h0, {34'h0, preq, slock, plocked, sta_o, resp});
		t_lock_seq;
		t_bad_first;
		t_abort;
		t_conflict;
		t_posted;
		t_primary;
		complete_run;
	end
endmodule
